// *** src/bfc_byte_reg.sv ***
`timescale 1ns/10ps
module bfc_byte_reg
#(
    parameter logic [7:0] MASK = 8'hFF,
    parameter logic [7:0] RESET = 8'h00
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] q
);
    // ------------------------------------------------------------
    // one byte, fixed-zero bits forced low
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            q <= RESET & MASK;
        end
        else if (wr)
        begin
            q <= wdata & MASK;
        end
    end
endmodule

// *** src/bfc_config_bank.sv ***
`timescale 1ns/10ps
module bfc_config_bank
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [bfc_pkg::ADDR_W-1:0] addr,
    input wire logic [bfc_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [bfc_pkg::DATA_W-1:0] rdata,
    output logic [2:0] rate_code_0,
    output logic [2:0] rate_code_1,
    output logic [2:0] ch_one_gain_0,
    output logic [2:0] ch_one_gain_1,
    output logic [2:0] ch_two_gain_0,
    output logic [2:0] ch_two_gain_1,
    output logic [3:0] ch_one_input_select_0,
    output logic [3:0] ch_one_input_select_1,
    output logic [3:0] ch_two_input_select_0,
    output logic [3:0] ch_two_input_select_1,
    output logic [3:0] drive_sel_0,
    output logic [3:0] drive_sel_1,
    output logic [1:0] drive_buffer_power,
    output logic [1:0] drive_detach_sense,
    output logic [1:0] drive_reference_internal,
    output logic [1:0] test_enable,
    output logic [1:0] test_wave_select,
    output logic [1:0] config_error
);
    import bfc_pkg::*;

    logic [7:0] bank [NUM_CHIPS][NUM_BYTES];
    logic [NUM_CHIPS-1:0] bad_now;
    logic [NUM_CHIPS-1:0] chip_sel;
    logic rd_chip;
    logic [NUM_BYTES-1:0] byte_hit;
    logic [3:0] idx;
    logic [7:0] next_rdata;

    assign idx = addr[3:0];
    assign rd_chip = addr[CHIP_SEL_BIT];
    assign chip_sel[0] = ~addr[CHIP_SEL_BIT];
    assign chip_sel[1] = addr[CHIP_SEL_BIT];

    // ------------------------------------------------------------
    // write decode, unmapped indexes hit nothing
    // ------------------------------------------------------------
    always_comb
    begin
        byte_hit = {NUM_BYTES{1'b0}};
        if (!wr_stb)
        begin
            byte_hit = {NUM_BYTES{1'b0}};
        end
        else if (idx == OFS_SAMPLE_RATE_CONFIG)
        begin
            byte_hit[OFS_SAMPLE_RATE_CONFIG] = 1'b1;
        end
        else if (idx == OFS_GENERAL_CONFIG_TWO)
        begin
            byte_hit[OFS_GENERAL_CONFIG_TWO] = 1'b1;
        end
        else if (idx == OFS_ELECTRODE_DETACH_CONTROL)
        begin
            byte_hit[OFS_ELECTRODE_DETACH_CONTROL] = 1'b1;
        end
        else if (idx == OFS_CHANNEL_ONE_SETTINGS)
        begin
            byte_hit[OFS_CHANNEL_ONE_SETTINGS] = 1'b1;
        end
        else if (idx == OFS_CHANNEL_TWO_SETTINGS)
        begin
            byte_hit[OFS_CHANNEL_TWO_SETTINGS] = 1'b1;
        end
        else if (idx == OFS_LEG_DRIVE_SENSE_SELECT)
        begin
            byte_hit[OFS_LEG_DRIVE_SENSE_SELECT] = 1'b1;
        end
        else if (idx == OFS_ELECTRODE_DETACH_SENSE_SELECT)
        begin
            byte_hit[OFS_ELECTRODE_DETACH_SENSE_SELECT] = 1'b1;
        end
        else if (idx == OFS_ELECTRODE_DETACH_STATE_SELECT)
        begin
            byte_hit[OFS_ELECTRODE_DETACH_STATE_SELECT] = 1'b1;
        end
        else if (idx == OFS_BREATHING_CONTROL_ONE)
        begin
            byte_hit[OFS_BREATHING_CONTROL_ONE] = 1'b1;
        end
        else if (idx == OFS_BREATHING_CONTROL_TWO)
        begin
            byte_hit[OFS_BREATHING_CONTROL_TWO] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // byte storage, one set per chip
    // ------------------------------------------------------------
    genvar c, b;
    generate
        for (c = 0; c < NUM_CHIPS; c++)
        begin : g_chip
            for (b = 0; b < NUM_BYTES; b++)
            begin : g_byte
                localparam logic [7:0] M =
                    (b == 0) ? MASK_RATE :
                    (b == 3 || b == 4) ? MASK_CHANNEL :
                    (b == 5) ? MASK_LEG_DRIVE : MASK_FULL;
                bfc_byte_reg #(.MASK(M), .RESET(RST_BYTE)) u_reg
                (
                    .mclk(mclk),
                    .nrst(nrst),
                    .wr(byte_hit[b] && chip_sel[c]),
                    .wdata(wdata),
                    .q(bank[c][b])
                );
            end
            bfc_rate_guard u_guard
            (
                .rate_byte(bank[c][OFS_SAMPLE_RATE_CONFIG]),
                .ch_one_byte(bank[c][OFS_CHANNEL_ONE_SETTINGS]),
                .ch_two_byte(bank[c][OFS_CHANNEL_TWO_SETTINGS]),
                .bad(bad_now[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        if (!rd_stb)
        begin
            next_rdata = 8'h00;
        end
        else if (idx == OFS_BANK_STATUS)
        begin
            next_rdata = {6'h00, config_error};
        end
        else if (idx == OFS_SAMPLE_RATE_CONFIG)
        begin
            next_rdata = bank[rd_chip][OFS_SAMPLE_RATE_CONFIG];
        end
        else if (idx == OFS_GENERAL_CONFIG_TWO)
        begin
            next_rdata = bank[rd_chip][OFS_GENERAL_CONFIG_TWO];
        end
        else if (idx == OFS_ELECTRODE_DETACH_CONTROL)
        begin
            next_rdata = bank[rd_chip][OFS_ELECTRODE_DETACH_CONTROL];
        end
        else if (idx == OFS_CHANNEL_ONE_SETTINGS)
        begin
            next_rdata = bank[rd_chip][OFS_CHANNEL_ONE_SETTINGS];
        end
        else if (idx == OFS_CHANNEL_TWO_SETTINGS)
        begin
            next_rdata = bank[rd_chip][OFS_CHANNEL_TWO_SETTINGS];
        end
        else if (idx == OFS_LEG_DRIVE_SENSE_SELECT)
        begin
            next_rdata = bank[rd_chip][OFS_LEG_DRIVE_SENSE_SELECT];
        end
        else if (idx == OFS_ELECTRODE_DETACH_SENSE_SELECT)
        begin
            next_rdata = bank[rd_chip][OFS_ELECTRODE_DETACH_SENSE_SELECT];
        end
        else if (idx == OFS_ELECTRODE_DETACH_STATE_SELECT)
        begin
            next_rdata = bank[rd_chip][OFS_ELECTRODE_DETACH_STATE_SELECT];
        end
        else if (idx == OFS_BREATHING_CONTROL_ONE)
        begin
            next_rdata = bank[rd_chip][OFS_BREATHING_CONTROL_ONE];
        end
        else if (idx == OFS_BREATHING_CONTROL_TWO)
        begin
            next_rdata = bank[rd_chip][OFS_BREATHING_CONTROL_TWO];
        end
        else
        begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // forbidden code status, follows the current image
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            config_error <= 2'h0;
        end
        else
        begin
            config_error <= bad_now;
        end
    end

    // ------------------------------------------------------------
    // decoded fields per chip
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            rate_code_0 <= 3'h0;
            rate_code_1 <= 3'h0;
        end
        else
        begin
            rate_code_0 <= bank[0][OFS_SAMPLE_RATE_CONFIG][RATE_LSB +: 3];
            rate_code_1 <= bank[1][OFS_SAMPLE_RATE_CONFIG][RATE_LSB +: 3];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ch_one_gain_0 <= 3'h0;
            ch_one_gain_1 <= 3'h0;
            ch_two_gain_0 <= 3'h0;
            ch_two_gain_1 <= 3'h0;
        end
        else
        begin
            ch_one_gain_0 <= bank[0][OFS_CHANNEL_ONE_SETTINGS][GAIN_LSB +: 3];
            ch_one_gain_1 <= bank[1][OFS_CHANNEL_ONE_SETTINGS][GAIN_LSB +: 3];
            ch_two_gain_0 <= bank[0][OFS_CHANNEL_TWO_SETTINGS][GAIN_LSB +: 3];
            ch_two_gain_1 <= bank[1][OFS_CHANNEL_TWO_SETTINGS][GAIN_LSB +: 3];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ch_one_input_select_0 <= 4'h0;
            ch_one_input_select_1 <= 4'h0;
            ch_two_input_select_0 <= 4'h0;
            ch_two_input_select_1 <= 4'h0;
        end
        else
        begin
            ch_one_input_select_0 <= bank[0][OFS_CHANNEL_ONE_SETTINGS][MUX_LSB +: 4];
            ch_one_input_select_1 <= bank[1][OFS_CHANNEL_ONE_SETTINGS][MUX_LSB +: 4];
            ch_two_input_select_0 <= bank[0][OFS_CHANNEL_TWO_SETTINGS][MUX_LSB +: 4];
            ch_two_input_select_1 <= bank[1][OFS_CHANNEL_TWO_SETTINGS][MUX_LSB +: 4];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            drive_sel_0 <= 4'h0;
            drive_sel_1 <= 4'h0;
            drive_buffer_power <= 2'h0;
            drive_detach_sense <= 2'h0;
            drive_reference_internal <= 2'h0;
        end
        else
        begin
            drive_sel_0 <= bank[0][OFS_LEG_DRIVE_SENSE_SELECT][DRIVE_SEL_LSB +: 4];
            drive_sel_1 <= bank[1][OFS_LEG_DRIVE_SENSE_SELECT][DRIVE_SEL_LSB +: 4];
            drive_buffer_power <= {
                bank[1][OFS_LEG_DRIVE_SENSE_SELECT][DRIVE_BUFFER_POWER_BIT],
                bank[0][OFS_LEG_DRIVE_SENSE_SELECT][DRIVE_BUFFER_POWER_BIT]};
            drive_detach_sense <= {
                bank[1][OFS_LEG_DRIVE_SENSE_SELECT][DRIVE_DETACH_SENSE_BIT],
                bank[0][OFS_LEG_DRIVE_SENSE_SELECT][DRIVE_DETACH_SENSE_BIT]};
            drive_reference_internal <= {
                bank[1][OFS_BREATHING_CONTROL_TWO][DRIVE_REF_INTERNAL_BIT],
                bank[0][OFS_BREATHING_CONTROL_TWO][DRIVE_REF_INTERNAL_BIT]};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            test_enable <= 2'h0;
            test_wave_select <= 2'h0;
        end
        else
        begin
            test_enable <= {
                bank[1][OFS_GENERAL_CONFIG_TWO][TEST_ENABLE_BIT],
                bank[0][OFS_GENERAL_CONFIG_TWO][TEST_ENABLE_BIT]};
            test_wave_select <= {
                bank[1][OFS_GENERAL_CONFIG_TWO][TEST_WAVE_SELECT_BIT],
                bank[0][OFS_GENERAL_CONFIG_TWO][TEST_WAVE_SELECT_BIT]};
        end
    end
endmodule

// *** src/bfc_pkg.sv ***
package bfc_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NUM_CHIPS = 2;
    localparam int NUM_BYTES = 10;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    // address: bit 4 selects the chip, bits 3..0 the byte index
    localparam int CHIP_SEL_BIT = 4;
    // ------------------------------------------------------------
    // byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_SAMPLE_RATE_CONFIG = 4'h0;
    localparam logic [3:0] OFS_GENERAL_CONFIG_TWO = 4'h1;
    localparam logic [3:0] OFS_ELECTRODE_DETACH_CONTROL = 4'h2;
    localparam logic [3:0] OFS_CHANNEL_ONE_SETTINGS = 4'h3;
    localparam logic [3:0] OFS_CHANNEL_TWO_SETTINGS = 4'h4;
    localparam logic [3:0] OFS_LEG_DRIVE_SENSE_SELECT = 4'h5;
    localparam logic [3:0] OFS_ELECTRODE_DETACH_SENSE_SELECT = 4'h6;
    localparam logic [3:0] OFS_ELECTRODE_DETACH_STATE_SELECT = 4'h7;
    localparam logic [3:0] OFS_BREATHING_CONTROL_ONE = 4'h8;
    localparam logic [3:0] OFS_BREATHING_CONTROL_TWO = 4'h9;
    // status byte of this block, read only
    localparam logic [3:0] OFS_BANK_STATUS = 4'hF;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RATE_LSB = 0;
    localparam int GAIN_LSB = 4;
    localparam int MUX_LSB = 0;
    localparam int DRIVE_SEL_LSB = 0;
    localparam int DRIVE_DETACH_SENSE_BIT = 4;
    localparam int DRIVE_BUFFER_POWER_BIT = 5;
    localparam int DRIVE_REF_INTERNAL_BIT = 1;
    localparam int TEST_WAVE_SELECT_BIT = 0;
    localparam int TEST_ENABLE_BIT = 1;
    // ------------------------------------------------------------
    // writable masks per byte (fixed-zero bits masked out)
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_RATE = 8'h07;
    localparam logic [7:0] MASK_CHANNEL = 8'h7F;
    localparam logic [7:0] MASK_LEG_DRIVE = 8'h3F;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ------------------------------------------------------------
    // forbidden codes
    // ------------------------------------------------------------
    localparam logic [2:0] RATE_FORBIDDEN = 3'h7;
    localparam logic [2:0] GAIN_FORBIDDEN = 3'h7;
    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BFC_SPS_125 = 3'b000,
        BFC_SPS_250 = 3'b001,
        BFC_SPS_500 = 3'b010,
        BFC_SPS_1000 = 3'b011,
        BFC_SPS_2000 = 3'b100,
        BFC_SPS_4000 = 3'b101,
        BFC_SPS_8000 = 3'b110
    } bfc_rate_t;
    typedef enum logic [1:0] {
        BFC_TEST_OFF = 2'b00,
        BFC_TEST_DC = 2'b10,
        BFC_TEST_SQUARE = 2'b11
    } bfc_test_t;
endpackage

// *** src/bfc_rate_guard.sv ***
`timescale 1ns/10ps
module bfc_rate_guard
(
    input wire logic [7:0] rate_byte,
    input wire logic [7:0] ch_one_byte,
    input wire logic [7:0] ch_two_byte,
    output logic bad
);
    import bfc_pkg::*;
    // ------------------------------------------------------------
    // flags a forbidden rate or gain code in one chip image
    // ------------------------------------------------------------
    always_comb
    begin
        bad = (rate_byte[RATE_LSB +: 3] == RATE_FORBIDDEN) ||
              (ch_one_byte[GAIN_LSB +: 3] == GAIN_FORBIDDEN) ||
              (ch_two_byte[GAIN_LSB +: 3] == GAIN_FORBIDDEN);
    end
endmodule

// *** verif/bfc_config_bank_assertions.sv ***
`timescale 1ns/10ps
module bfc_checker
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [bfc_pkg::ADDR_W-1:0] addr,
    input wire logic [bfc_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [bfc_pkg::DATA_W-1:0] rdata,
    input wire logic [2:0] rate_code_0,
    input wire logic [2:0] rate_code_1,
    input wire logic [2:0] ch_one_gain_0,
    input wire logic [3:0] ch_one_input_select_0,
    input wire logic [2:0] ch_two_gain_1,
    input wire logic [3:0] ch_two_input_select_1,
    input wire logic [3:0] drive_sel_0,
    input wire logic [1:0] drive_buffer_power,
    input wire logic [1:0] drive_reference_internal,
    input wire logic [1:0] test_enable,
    input wire logic [1:0] test_wave_select
);
    import bfc_pkg::*;
    // ------
    // checks
    // ------
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_wr(logic [4:0] a);
        wr_stb && addr == a;
    endsequence
    sequence s_quiet;
        !wr_stb ##1 !wr_stb;
    endsequence
    property p_rate0;
        s_wr(5'h00) |-> ##2 rate_code_0 == $past(wdata[2:0], 2);
    endproperty
    a_rate0: assert property (p_rate0) else $error("rate 0");
    property p_rate1;
        s_wr(5'h10) |-> ##2 rate_code_1 == $past(wdata[2:0], 2);
    endproperty
    a_rate1: assert property (p_rate1) else $error("rate 1");
    property p_ch1;
        s_wr(5'h03) |-> ##2 ch_one_gain_0 == $past(wdata[6:4], 2)
            && ch_one_input_select_0 == $past(wdata[3:0], 2);
    endproperty
    a_ch1: assert property (p_ch1) else $error("channel one");
    property p_ch2;
        s_wr(5'h14) |-> ##2 ch_two_gain_1 == $past(wdata[6:4], 2)
            && ch_two_input_select_1 == $past(wdata[3:0], 2);
    endproperty
    a_ch2: assert property (p_ch2) else $error("channel two");
    property p_drive;
        s_wr(5'h05) |-> ##2 drive_sel_0 == $past(wdata[3:0], 2)
            && drive_buffer_power[0] == $past(wdata[5], 2);
    endproperty
    a_drive: assert property (p_drive) else $error("drive");
    property p_ref;
        s_wr(5'h19) |-> ##2 drive_reference_internal[1] == $past(wdata[1], 2);
    endproperty
    a_ref: assert property (p_ref) else $error("reference");
    property p_test;
        s_wr(5'h01) |-> ##2 {test_enable[0], test_wave_select[0]}
            == $past(wdata[1:0], 2);
    endproperty
    a_test: assert property (p_test) else $error("test signal");
    property p_hold;
        s_quiet |=> $stable(rate_code_1) && $stable(drive_sel_0);
    endproperty
    a_hold: assert property (p_hold) else $error("field moved");
    property p_idle;
        !rd_stb |=> rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    property p_unmap;
        rd_stb && addr[3:0] inside {[4'hA:4'hE]} |=> rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
endmodule
bind bfc_config_bank bfc_checker bfc_checker_inst (.mclk, .nrst, .addr,
    .wdata, .wr_stb, .rd_stb, .rdata, .rate_code_0, .rate_code_1,
    .ch_one_gain_0, .ch_one_input_select_0, .ch_two_gain_1,
    .ch_two_input_select_1, .drive_sel_0, .drive_buffer_power,
    .drive_reference_internal, .test_enable, .test_wave_select);

// *** verif/bfc_config_bank_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module bfc_config_bank_tb_top;
    import bfc_pkg::*;
    logic mclk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, rdata;
    logic [2:0] r0, r1, g10, g11, g20, g21;
    logic [3:0] m10, m11, m20, m21, d0, d1;
    logic [1:0] pw, ds, ri, te, tw, ce;
    int checks = 0, fail_count = 0;
    bfc_config_bank bfc_config_bank_inst (.mclk(mclk), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .rate_code_0(r0), .rate_code_1(r1),
        .ch_one_gain_0(g10), .ch_one_gain_1(g11), .ch_two_gain_0(g20),
        .ch_two_gain_1(g21), .ch_one_input_select_0(m10),
        .ch_one_input_select_1(m11), .ch_two_input_select_0(m20),
        .ch_two_input_select_1(m21), .drive_sel_0(d0), .drive_sel_1(d1),
        .drive_buffer_power(pw), .drive_detach_sense(ds),
        .drive_reference_internal(ri), .test_enable(te),
        .test_wave_select(tw), .config_error(ce));
    always #5 mclk = ~mclk;
    // ------
    // bus tasks
    // ------
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task rc(input logic [4:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ------
    // scenarios
    // ------
    task t_reset;
        for (int i = 0; i < 10; i++)
        begin
            rc(5'(i), 8'h00);
            rc(5'(16 + i), 8'h00);
        end
        `CHK({r0, r1, g10, g21, d0, pw, ri, te, ce}, 24'h0)
        $display("test reset done");
    endtask
    task t_rate;
        for (int c = 0; c < 7; c++)
        begin
            wr(5'h00, 8'hF8 | 8'(c));
            wr(5'h10, 8'(6 - c));
            settle();
            `CHK(r0, 3'(c))
            `CHK(r1, 3'(6 - c))
            rc(5'h00, 8'(c));
        end
        $display("test rate done");
    endtask
    task t_gain;
        for (int g = 0; g < 7; g++)
        begin
            wr(5'h03, {1'b1, 3'(g), 4'(g + 1)});
            wr(5'h14, {1'b1, 3'(6 - g), 4'(15 - g)});
            settle();
            `CHK({g10, m10}, {3'(g), 4'(g + 1)})
            `CHK({g21, m21}, {3'(6 - g), 4'(15 - g)})
            `CHK({g11, m11, g20, m20}, 14'h0)
            rc(5'h03, {1'b0, 3'(g), 4'(g + 1)});
        end
        $display("test gain done");
    endtask
    task t_drive;
        wr(5'h05, 8'hFF);
        wr(5'h15, 8'h2D);
        wr(5'h09, 8'h02);
        wr(5'h19, 8'hFD);
        settle();
        `CHK({d0, d1}, 8'hFD)
        `CHK({pw, ds}, 4'hD)
        `CHK(ri, 2'h1)
        rc(5'h05, 8'h3F);
        rc(5'h19, 8'hFD);
        $display("test drive done");
    endtask
    task t_test;
        static bfc_test_t m [3] =
            '{BFC_TEST_OFF, BFC_TEST_DC, BFC_TEST_SQUARE};
        for (int i = 0; i < 3; i++)
        begin
            wr(5'h01, {6'h28, m[i]});
            wr(5'h11, {6'h2A, m[2 - i]});
            settle();
            `CHK({te, tw}, {m[2 - i][1], m[i][1], m[2 - i][0], m[i][0]})
            rc(5'h01, {6'h28, m[i]});
        end
        $display("test signal done");
    endtask
    task t_err;
        wr(5'h0A, 8'h55);
        rc(5'h0A, 8'h00);
        rc(5'h1F, 8'h00);
        wr(5'h10, 8'h07);
        settle();
        `CHK(ce, 2'h2)
        rc(5'h1F, 8'h02);
        wr(5'h04, 8'h70);
        settle();
        `CHK(ce, 2'h3)
        @(posedge mclk);
        nrst <= 1'b0;
        @(posedge mclk);
        nrst <= 1'b1;
        settle();
        `CHK({ce, r0, d0}, 9'h0)
        rc(5'h03, 8'h00);
        $display("test error done");
    endtask
    task t_image;
        for (int c = 0; c < 2; c++)
        begin
            wr({1'(c), 4'h0}, 8'h02);
            wr({1'(c), 4'h1}, 8'hA8);
            wr({1'(c), 4'h2}, 8'h10);
            wr({1'(c), 4'h3}, 8'h40);
            wr({1'(c), 4'h4}, c ? 8'h47 : 8'h40);
            wr({1'(c), 4'h5}, c ? 8'h00 : 8'h2D);
            wr({1'(c), 4'h6}, 8'h00);
            wr({1'(c), 4'h7}, 8'h00);
            wr({1'(c), 4'h8}, 8'h02);
            wr({1'(c), 4'h9}, c ? 8'h01 : 8'h03);
        end
        settle();
        `CHK({r0, r1}, 6'h12)
        `CHK({g10, g11, g20, g21}, 12'h924)
        `CHK({m10, m11, m20, m21}, 16'h0007)
        `CHK({d0, d1, pw, ds, ri}, 14'h3411)
        `CHK({te, tw, ce}, 6'h00)
        rc(5'h11, 8'hA8);
        rc(5'h12, 8'h10);
        rc(5'h18, 8'h02);
        wr(5'h05, 8'h20);
        settle();
        `CHK({d0, d1, pw}, 10'h001)
        $display("test image done");
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_rate();
        t_gain();
        t_drive();
        t_test();
        t_err();
        t_image();
        summarize();
    end
    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule
